// ==== logic/tpg_gate_ctrl.v ====
// Our own choices: the Wishbone slave port and the address map.
`include "tpg_defs.vh"
module tpg_gate_ctrl #(
  parameter SLEEP_CYC = `TPG_SLEEP_ENTRY_US * `TPG_CLK_MHZ,
  parameter SETTLE_CYC = `TPG_CP_SETTLE_US * `TPG_CLK_MHZ
) (
  // Clock and reset
  input wire SYS_CLK,
  input wire NRST,
  // Phase and chop commands
  input wire PHASE_A_HI_CMD,
  input wire PHASE_B_HI_CMD,
  input wire PHASE_C_HI_CMD,
  input wire PHASE_A_LO_CMD,
  input wire PHASE_B_LO_CMD,
  input wire PHASE_C_LO_CMD,
  input wire HI_CHOP_IN,
  input wire LO_CHOP_IN,
  // Mode and sleep pins
  input wire FREEWHEEL_N,
  input wire SLEEP_RESET_N,
  input wire SHOOT_THROUGH_ENABLE,
  input wire STOP_ON_FAULT_SEL,
  input wire DEADTIME_AT_GROUND,
  // Fault detector levels
  input wire [5:0] SHORT_DET,
  input wire OVERTEMP_DET,
  input wire VDD_UV_DET,
  input wire VREG_UV_DET,
  input wire [2:0] BOOT_UV_DET,
  // Gate drive
  output reg [2:0] HI_GATE_OUT,
  output reg [2:0] LO_GATE_OUT,
  output reg GATE_OE,
  // Open-drain fault flags
  input wire FAULT_FLAG_B_IN,
  output wire FAULT_FLAG_A_OUT,
  output reg FAULT_FLAG_A_OE,
  output wire FAULT_FLAG_B_OUT,
  output reg FAULT_FLAG_B_OE,
  // Wishbone slave
  input wire CYC_I,
  input wire STB_I,
  input wire WE_I,
  input wire [3:0] ADR_I,
  input wire [3:0] SEL_I,
  input wire [31:0] DAT_I,
  output reg [31:0] DAT_O,
  output reg ACK_O
);
  localparam FW = `TPG_FAULT_W;
  localparam [3:0] ST_INIT = 4'h1;
  localparam [3:0] ST_RUN = 4'h2;
  localparam [3:0] ST_SLEEP = 4'h4;
  localparam [3:0] ST_WAKE = 4'h8;
  localparam [31:0] SLEEP_N = SLEEP_CYC;
  localparam [31:0] SETTLE_N = SETTLE_CYC;
  localparam [31:0] INIT_N = `TPG_INIT_CYCLES;

  // Phase decode: returns {high gate, low gate}
  function [1:0] phase_dec;
    input hi;
    input lo;
    input ph;
    input pl;
    input dt_off;
    input cc;
    begin
      case ({hi, lo})
        2'b01: phase_dec = {~pl, pl};
        2'b10: phase_dec = {ph, ~ph};
        2'b11: begin
          if (!dt_off)
            phase_dec = 2'b00;
          else if (ph & ~pl)
            phase_dec = 2'b10;
          else if (~ph & pl)
            phase_dec = 2'b01;
          else if (ph & pl & cc)
            phase_dec = 2'b11;
          else
            phase_dec = 2'b00;
        end
        default: phase_dec = 2'b00;
      endcase
    end
  endfunction

  // Pin synchronisers
  wire [13:0] pins_raw;
  wire [13:0] pins;
  assign pins_raw = {FAULT_FLAG_B_IN, DEADTIME_AT_GROUND, STOP_ON_FAULT_SEL,
    SHOOT_THROUGH_ENABLE, SLEEP_RESET_N, FREEWHEEL_N, LO_CHOP_IN,
    HI_CHOP_IN, PHASE_C_LO_CMD, PHASE_B_LO_CMD, PHASE_A_LO_CMD,
    PHASE_C_HI_CMD, PHASE_B_HI_CMD, PHASE_A_HI_CMD};

  tpg_sync #(
    .W(14)
  ) u_sync (
    .clk(SYS_CLK),
    .nrst(NRST),
    .din(pins_raw),
    .q(pins)
  );

  wire [2:0] hi_cmd = pins[2:0];
  wire [2:0] lo_cmd = pins[5:3];
  wire chop_h = pins[6];
  wire chop_l = pins[7];
  wire freewheel_n = pins[8];
  wire sleep_n = pins[9];
  wire cc_en = pins[10];
  wire stop_on_fault_sel = pins[11];
  wire dt_off = pins[12];
  wire ser_clk = pins[13];

  // Fault detector levels
  wire [FW-1:0] fault_now;
  wire ser_done;
  wire pulse_clear;
  wire sw_clear;
  assign fault_now = {VDD_UV_DET, BOOT_UV_DET, VREG_UV_DET, OVERTEMP_DET,
    SHORT_DET};

  reg [3:0] state_q;
  reg [31:0] cnt_q;
  reg [FW-1:0] fault_reg_q;
  reg short_lat_q;
  reg boot_lat_q;
  reg [1:0] ctrl_q;
  reg ser_clk_q;
  reg [FW-1:0] ser_sh_q;
  reg [3:0] ser_cnt_q;
  reg ser_bit_q;
  reg ser_arm_q;
  reg ser_tail_q;

  // Sleep, wake and init sequencing
  wire run = state_q == ST_RUN;
  wire enter_sleep = run && !sleep_n && cnt_q + 32'h1 >= SLEEP_N;
  assign pulse_clear = run && sleep_n && cnt_q != 32'h0;

  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      state_q <= ST_INIT;
      cnt_q <= 32'h0;
    end else begin
      case (state_q)
        ST_INIT: begin
          if (cnt_q + 32'h1 >= INIT_N) begin
            state_q <= ST_RUN;
            cnt_q <= 32'h0;
          end else
            cnt_q <= cnt_q + 32'h1;
        end
        ST_RUN: begin
          if (enter_sleep) begin
            state_q <= ST_SLEEP;
            cnt_q <= 32'h0;
          end else if (!sleep_n)
            cnt_q <= cnt_q + 32'h1;
          else
            cnt_q <= 32'h0;
        end
        ST_SLEEP: begin
          if (sleep_n) begin
            state_q <= ST_WAKE;
            cnt_q <= 32'h0;
          end
        end
        ST_WAKE: begin
          if (!sleep_n) begin
            state_q <= ST_SLEEP;
            cnt_q <= 32'h0;
          end else if (cnt_q + 32'h1 >= SETTLE_N) begin
            state_q <= ST_RUN;
            cnt_q <= 32'h0;
          end else
            cnt_q <= cnt_q + 32'h1;
        end
        default: begin
          state_q <= ST_INIT;
          cnt_q <= 32'h0;
        end
      endcase
    end
  end

  // Latched faults; freewheel plays no part here
  wire any_short = |SHORT_DET;
  wire any_boot = |BOOT_UV_DET;
  wire sleeping = state_q == ST_SLEEP;
  wire clr_lat = sleeping | pulse_clear | sw_clear;

  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      fault_reg_q <= {FW{1'b0}};
      short_lat_q <= 1'b0;
      boot_lat_q <= 1'b0;
    end else begin
      if (sleeping)
        fault_reg_q <= {FW{1'b0}};
      else if (clr_lat || ser_done)
        fault_reg_q <= fault_now;
      else
        fault_reg_q <= fault_reg_q | fault_now;
      if (sleeping)
        short_lat_q <= 1'b0;
      else if (any_short && stop_on_fault_sel)
        short_lat_q <= 1'b1;
      else if (clr_lat || ser_done)
        short_lat_q <= 1'b0;
      if (sleeping)
        boot_lat_q <= 1'b0;
      else if (any_boot)
        boot_lat_q <= 1'b1;
      else if (clr_lat)
        boot_lat_q <= 1'b0;
    end
  end

  // Fault flag levels
  wire uv_now = VDD_UV_DET | VREG_UV_DET | boot_lat_q;
  wire short_flag = any_short | short_lat_q;
  wire flag_a = OVERTEMP_DET | uv_now;
  wire flag_b = short_flag | uv_now;
  wire ser_ok = (short_flag | uv_now) & ~OVERTEMP_DET;
  wire out_dis = uv_now | (stop_on_fault_sel & (short_lat_q | OVERTEMP_DET));

  // Serial fault word, MSB first, one bit per rising clock on flag b
  // Edges count only once the released flag b was seen high
  wire ser_rise = ser_clk & ~ser_clk_q & ser_arm_q;
  wire ser_fall = ~ser_clk & ser_clk_q;
  assign ser_done = ser_rise && ser_cnt_q == FW[3:0] - 4'h1;

  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      ser_clk_q <= 1'b0;
      ser_arm_q <= 1'b0;
      ser_sh_q <= {FW{1'b0}};
      ser_cnt_q <= 4'h0;
      ser_bit_q <= 1'b0;
      ser_tail_q <= 1'b0;
    end else begin
      ser_clk_q <= ser_clk;
      ser_arm_q <= ser_ok && !sleeping &&
        (ser_arm_q || (ser_clk && !FAULT_FLAG_B_OE));
      if (!ser_ok || sleeping) begin
        ser_cnt_q <= 4'h0;
        ser_bit_q <= 1'b0;
        ser_tail_q <= 1'b0;
      end else if (ser_rise) begin
        if (ser_cnt_q == 4'h0) begin
          ser_bit_q <= fault_reg_q[FW-1];
          ser_sh_q <= {fault_reg_q[FW-2:0], 1'b0};
        end else begin
          ser_bit_q <= ser_sh_q[FW-1];
          ser_sh_q <= {ser_sh_q[FW-2:0], 1'b0};
        end
        if (ser_done)
          ser_cnt_q <= 4'h0;
        else
          ser_cnt_q <= ser_cnt_q + 4'h1;
        ser_tail_q <= ser_done; // Last bit stands until the clock falls
      end else if (ser_fall)
        ser_tail_q <= 1'b0;
      else if (ser_cnt_q == 4'h0 && !ser_tail_q)
        ser_bit_q <= 1'b0;
    end
  end

  // Flags are open drain: low driven, high released
  wire ser_active = ser_ok && (ser_cnt_q != 4'h0 || ser_tail_q);
  assign FAULT_FLAG_A_OUT = 1'b0;
  assign FAULT_FLAG_B_OUT = 1'b0;

  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      FAULT_FLAG_A_OE <= 1'b1;
      FAULT_FLAG_B_OE <= 1'b1;
    end else begin
      FAULT_FLAG_A_OE <= ser_active ? ~ser_bit_q : ~flag_a;
      FAULT_FLAG_B_OE <= ~flag_b;
    end
  end

  // Gate decode and override
  reg [1:0] dec;
  reg [2:0] hi_d;
  reg [2:0] lo_d;
  integer i;
  wire gates_off = !run || !freewheel_n || out_dis ||
    ctrl_q[`TPG_CTRL_FREEWHEEL];
  wire cc_ok = dt_off & cc_en;

  always @* begin
    dec = 2'b00;
    hi_d = 3'h0;
    lo_d = 3'h0;
    for (i = 0; i < 3; i = i + 1) begin
      dec = phase_dec(hi_cmd[i], lo_cmd[i], chop_h, chop_l, dt_off, cc_ok);
      hi_d[i] = dec[1] & ~gates_off;
      lo_d[i] = dec[0] & ~gates_off;
    end
  end

  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      HI_GATE_OUT <= 3'h0;
      LO_GATE_OUT <= 3'h0;
      GATE_OE <= 1'b1;
    end else begin
      HI_GATE_OUT <= hi_d;
      LO_GATE_OUT <= lo_d;
      GATE_OE <= !sleeping;
    end
  end

  // Wishbone slave
  wire bus_req = CYC_I & STB_I & ~ACK_O;
  wire wr_ctrl = CYC_I & STB_I & ACK_O & WE_I & SEL_I[0] &
    ADR_I == `TPG_REG_CTRL;
  assign sw_clear = wr_ctrl & DAT_I[`TPG_CTRL_CLEAR];

  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h0;
      ctrl_q <= `TPG_CTRL_RST;
    end else begin
      ACK_O <= bus_req;
      if (wr_ctrl)
        ctrl_q <= {1'b0, DAT_I[`TPG_CTRL_FREEWHEEL]};
      if (bus_req && !WE_I) begin
        case (ADR_I)
          `TPG_REG_CTRL: DAT_O <= {30'h0, ctrl_q};
          `TPG_REG_STATUS: DAT_O <= {16'h0, stop_on_fault_sel, dt_off, cc_en, out_dis,
            flag_b, flag_a, state_q, LO_GATE_OUT, HI_GATE_OUT};
          `TPG_REG_FAULT: DAT_O <= {{(32-FW){1'b0}}, fault_reg_q};
          default: DAT_O <= 32'h0;
        endcase
      end else
        DAT_O <= 32'h0;
    end
  end
endmodule // tpg_gate_ctrl

// ==== logic/tpg_defs.vh ====
`ifndef TPG_DEFS_VH
`define TPG_DEFS_VH
// Clock rate in MHz
`define TPG_CLK_MHZ 25
// Sleep entry time in microseconds
`define TPG_SLEEP_ENTRY_US 100
// Charge pump settle time in microseconds
`define TPG_CP_SETTLE_US 3000
// Cycles of settled input sampling after reset
`define TPG_INIT_CYCLES 8
// Register byte offsets
`define TPG_REG_CTRL 4'h0
`define TPG_REG_STATUS 4'h4
`define TPG_REG_FAULT 4'h8
// Control fields
`define TPG_CTRL_FREEWHEEL 0
`define TPG_CTRL_CLEAR 1
`define TPG_CTRL_RST 2'h0
// Fault word width and field positions
`define TPG_FAULT_W 12
`define TPG_FB_SHORT 0
`define TPG_FB_OTEMP 6
`define TPG_FB_VREG_UV 7
`define TPG_FB_BOOT_UV 8
`define TPG_FB_VDD_UV 11
`endif

// ==== logic/tpg_sync.v ====
module tpg_sync #(
  parameter W = 1
) (
  input wire clk,
  input wire nrst,
  input wire [W-1:0] din,
  output reg [W-1:0] q
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;

  // A bit changes once the second and third stages agree
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q <= (s2_q & s3_q) | (q & (s2_q | s3_q));
    end
  end
endmodule // tpg_sync

// ==== dv/tpg_gate_ctrl_sva.sv ====
module tpg_gate_ctrl_sva #(
  parameter SLEEP_CYC = 20,
  parameter SETTLE_CYC = 30
) (
  // Clock and reset
  input wire SYS_CLK,
  input wire NRST,
  // Pins
  input wire FREEWHEEL_N,
  input wire SLEEP_RESET_N,
  input wire SHOOT_THROUGH_ENABLE,
  input wire DEADTIME_AT_GROUND,
  input wire STOP_ON_FAULT_SEL,
  input wire OVERTEMP_DET,
  // Gates
  input wire [2:0] HI_GATE_OUT,
  input wire [2:0] LO_GATE_OUT,
  input wire GATE_OE,
  // Bus
  input wire CYC_I,
  input wire STB_I,
  input wire [31:0] DAT_O,
  input wire ACK_O
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cc_q, slp_q, wk_q;
  logic [3:0] ini_q;
  wire off = (HI_GATE_OUT | LO_GATE_OUT) == 3'h0;
  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      cc_q <= 16'h0;
      slp_q <= 16'h0;
      wk_q <= 16'h0;
      ini_q <= 4'h0;
    end else begin
      if (SHOOT_THROUGH_ENABLE && DEADTIME_AT_GROUND)
        cc_q <= 16'h0;
      else if (cc_q < 16'h8)
        cc_q <= cc_q + 16'h1;
      if (SLEEP_RESET_N)
        slp_q <= 16'h0;
      else if (slp_q != 16'hffff)
        slp_q <= slp_q + 16'h1;
      if ($rose(GATE_OE))
        wk_q <= 16'h1;
      else if (wk_q != 16'h0 && wk_q < SETTLE_CYC - 1)
        wk_q <= wk_q + 16'h1;
      else
        wk_q <= 16'h0;
      if (ini_q < 4'h8)
        ini_q <= ini_q + 4'h1;
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  a_ack_next: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("ack missing");
  a_ack_pulse: assert property (ACK_O |=> !ACK_O)
    else $error("ack too long");
  a_dat_idle: assert property (!ACK_O |-> DAT_O == 32'h0)
    else $error("data outside ack");
  a_no_shoot: assert property (cc_q >= 16'h6 |-> !(|(HI_GATE_OUT & LO_GATE_OUT)))
    else $error("both gates on");
  a_coast_off: assert property ((!FREEWHEEL_N)[*7] |-> off)
    else $error("gates on in coast");
  a_stop_fault: assert property ((STOP_ON_FAULT_SEL && OVERTEMP_DET)[*7] |-> off)
    else $error("gates on in fault");
  a_sleep_entry: assert property ($fell(GATE_OE) |-> slp_q >= SLEEP_CYC)
    else $error("early sleep");
  a_wake_hold: assert property (wk_q != 16'h0 |-> off)
    else $error("gates on in settle");
  a_init_hold: assert property (ini_q < 4'h8 |-> off)
    else $error("gates on after reset");
endmodule // tpg_gate_ctrl_sva

// ==== dv/tpg_ctrl_model.sv ====
module tpg_ctrl_model (
  // Clock
  input wire clk,
  // Phase and chop pins
  output logic [2:0] hi_cmd,
  output logic [2:0] lo_cmd,
  output logic hi_chop,
  output logic lo_chop,
  // Mode pins
  output logic freewheel_n,
  output logic sleep_rst_n,
  // Fault flag pins
  input wire flag_a,
  output logic ser_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    hi_cmd = 3'h0;
    lo_cmd = 3'h0;
    hi_chop = 1'b1;
    lo_chop = 1'b1;
    freewheel_n = 1'b1;
    sleep_rst_n = 1'b1;
    ser_clk = 1'b1;
  end
  // Clock flag b low then released, sample flag a per bit
  task read_word(output logic [11:0] w);
    w = 12'h000;
    for (int k = 0; k < 12; k++) begin
      @(posedge clk);
      ser_clk <= 1'b0;
      repeat (7) @(posedge clk);
      ser_clk <= 1'b1;
      repeat (8) @(posedge clk);
      w = {w[10:0], flag_a};
    end
  endtask
  task drive(input logic [2:0] h, input logic [2:0] l, input logic c1,
             input logic c2);
    @(posedge clk);
    hi_cmd <= h;
    lo_cmd <= l;
    hi_chop <= c1;
    lo_chop <= c2;
  endtask
  task coast(input logic v);
    @(posedge clk);
    freewheel_n <= v;
  endtask
  // Short pulse clears faults, long pulse sleeps
  task rst_low(input int n);
    @(posedge clk);
    sleep_rst_n <= 1'b0;
    repeat (n) @(posedge clk);
    sleep_rst_n <= 1'b1;
  endtask
endmodule // tpg_ctrl_model

// ==== dv/tpg_gate_ctrl_tb.sv ====
module tpg_gate_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SLP = 20;
  localparam int STL = 30;
  logic clk = 0, nrst = 0, st_en = 0, dt_gnd = 0, stop_on_fault_sel = 0, otemp = 0;
  logic cyc = 0, stb = 0, we = 0;
  logic [5:0] short = 6'h0;
  logic vdd_uv = 0, vreg_uv = 0;
  logic [2:0] boot_uv = 3'h0;
  wire fa_out, fa_oe, fb_out, fb_oe, ser_ck;
  wire ffa_pin = ~fa_oe;
  wire ffb_pin = ser_ck & ~fb_oe;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] dat = 32'h0, rd;
  wire [31:0] dat_o;
  wire ack, oe, ch_h, ch_l, fw_n, slp_n;
  wire [2:0] hi, lo, ph_h, ph_l;
  int failures = 0, cmp_count = 0;
  always #20 clk = ~clk;
  tpg_ctrl_model pm (.clk(clk), .hi_cmd(ph_h), .lo_cmd(ph_l),
    .hi_chop(ch_h), .lo_chop(ch_l), .freewheel_n(fw_n),
    .sleep_rst_n(slp_n), .flag_a(ffa_pin), .ser_clk(ser_ck));
  tpg_gate_ctrl #(.SLEEP_CYC(SLP), .SETTLE_CYC(STL)) uut (
    .SYS_CLK(clk), .NRST(nrst), .PHASE_A_HI_CMD(ph_h[0]),
    .PHASE_B_HI_CMD(ph_h[1]), .PHASE_C_HI_CMD(ph_h[2]),
    .PHASE_A_LO_CMD(ph_l[0]), .PHASE_B_LO_CMD(ph_l[1]),
    .PHASE_C_LO_CMD(ph_l[2]), .HI_CHOP_IN(ch_h), .LO_CHOP_IN(ch_l),
    .FREEWHEEL_N(fw_n), .SLEEP_RESET_N(slp_n),
    .SHOOT_THROUGH_ENABLE(st_en), .STOP_ON_FAULT_SEL(stop_on_fault_sel),
    .DEADTIME_AT_GROUND(dt_gnd), .SHORT_DET(short), .OVERTEMP_DET(otemp),
    .VDD_UV_DET(vdd_uv), .VREG_UV_DET(vreg_uv), .BOOT_UV_DET(boot_uv),
    .HI_GATE_OUT(hi), .LO_GATE_OUT(lo), .GATE_OE(oe),
    .FAULT_FLAG_B_IN(ffb_pin), .FAULT_FLAG_A_OUT(fa_out),
    .FAULT_FLAG_A_OE(fa_oe), .FAULT_FLAG_B_OUT(fb_out),
    .FAULT_FLAG_B_OE(fb_oe), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(dat_o),
    .ACK_O(ack));
  task chk(input logic ok, input string m);
    cmp_count++;
    if (!ok) begin
      failures++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    dat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    rd = dat_o;
    chk(n == 2, "ack timing");
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  function logic [1:0] ex(input logic h, l, c1, c2, dt, cc);
    if (h && l) return !dt ? 2'b00 : (c1 && c2) ? {cc, cc} : {c1, c2};
    if (h) return {c1, !c1};
    if (l) return {!c2, c2};
    return 2'b00;
  endfunction
  task t_table;
    logic h, l, c1, c2, dt, cc;
    for (int k = 0; k < 64; k++) begin
      {h, l, c1, c2, dt, cc} = 6'(k);
      dt_gnd <= dt;
      st_en <= cc;
      pm.drive({h, l, h}, {l, h, l}, c1, c2);
      repeat (8) @(posedge clk);
      chk({hi[0], lo[0]} === ex(h, l, c1, c2, dt, cc), "ph a");
      chk({hi[1], lo[1]} === ex(l, h, c1, c2, dt, cc), "ph b");
      chk({hi[2], lo[2]} === ex(h, l, c1, c2, dt, cc), "ph c");
    end
    dt_gnd <= 1'b0;
    st_en <= 1'b0;
  endtask
  task t_coast;
    pm.drive(3'h1, 3'h0, 1'b1, 1'b1);
    short <= 6'h01;
    pm.coast(1'b0);
    repeat (8) @(posedge clk);
    chk((hi | lo) === 3'h0, "coast");
    wb(1'b0, 4'h8, 32'h0);
    chk(rd[11:0] === 12'h001, "word");
    short <= 6'h0;
    pm.coast(1'b1);
    pm.rst_low(5);
    repeat (8) @(posedge clk);
    wb(1'b0, 4'h8, 32'h0);
    chk(rd[11:0] === 12'h000, "clear");
    wb(1'b0, 4'hc, 32'h0);
    chk(rd === 32'h0, "unmapped");
    wb(1'b1, 4'h0, 32'h1);
    repeat (8) @(posedge clk);
    chk((hi | lo) === 3'h0, "sw coast");
    wb(1'b0, 4'h0, 32'h0);
    chk(rd[1:0] === 2'b01, "ctrl read");
    wb(1'b1, 4'h0, 32'h0);
  endtask
  task t_stop;
    stop_on_fault_sel <= 1'b1;
    short <= 6'h01;
    repeat (8) @(posedge clk);
    short <= 6'h0;
    repeat (8) @(posedge clk);
    chk((hi | lo) === 3'h0, "latched");
    wb(1'b1, 4'h0, 32'h2);
    repeat (8) @(posedge clk);
    chk(hi === 3'h1, "unlatched");
    otemp <= 1'b1;
    repeat (8) @(posedge clk);
    chk((hi | lo) === 3'h0, "overtemp");
    otemp <= 1'b0;
    stop_on_fault_sel <= 1'b0;
  endtask
  task t_sleep;
    short <= 6'h08;
    repeat (4) @(posedge clk);
    short <= 6'h0;
    pm.rst_low(SLP + 10);
    chk(oe === 1'b0, "sleep");
    repeat (12) @(posedge clk);
    chk((hi | lo) === 3'h0, "settle");
    repeat (STL + 10) @(posedge clk);
    chk(hi === 3'h1 && oe === 1'b1, "wake");
    wb(1'b0, 4'h8, 32'h0);
    chk(rd[11:0] === 12'h000, "sleep clear");
  endtask
  task t_serial;
    logic [11:0] w;
    short <= 6'h02;
    boot_uv <= 3'h4;
    vreg_uv <= 1'b1;
    vdd_uv <= 1'b1;
    repeat (10) @(posedge clk);
    chk(ffa_pin === 1'b1 && ffb_pin === 1'b1, "flags");
    chk(fa_out === 1'b0 && fb_out === 1'b0, "open drain");
    wb(1'b0, 4'h4, 32'h0);
    chk(rd === 32'h00001c80, "status");
    pm.read_word(w);
    chk(w === 12'hc82, "serial word");
    short <= 6'h0;
    boot_uv <= 3'h0;
    vreg_uv <= 1'b0;
    vdd_uv <= 1'b0;
    repeat (8) @(posedge clk);
    wb(1'b1, 4'h0, 32'h2);
    repeat (8) @(posedge clk);
    chk(hi === 3'h1, "uv clear");
    wb(1'b0, 4'h8, 32'h0);
    chk(rd[11:0] === 12'h000, "word clear");
  endtask
  task results;
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (12) @(posedge clk);
    t_table;
    t_coast;
    t_stop;
    t_sleep;
    t_serial;
    results;
  end
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    results;
  end
endmodule // tpg_gate_ctrl_tb
bind tpg_gate_ctrl tpg_gate_ctrl_sva #(.SLEEP_CYC(SLEEP_CYC),
  .SETTLE_CYC(SETTLE_CYC)) u_sva (.SYS_CLK(SYS_CLK), .NRST(NRST),
  .FREEWHEEL_N(FREEWHEEL_N), .SLEEP_RESET_N(SLEEP_RESET_N),
  .SHOOT_THROUGH_ENABLE(SHOOT_THROUGH_ENABLE),
  .DEADTIME_AT_GROUND(DEADTIME_AT_GROUND),
  .STOP_ON_FAULT_SEL(STOP_ON_FAULT_SEL), .OVERTEMP_DET(OVERTEMP_DET),
  .HI_GATE_OUT(HI_GATE_OUT), .LO_GATE_OUT(LO_GATE_OUT),
  .GATE_OE(GATE_OE), .CYC_I(CYC_I), .STB_I(STB_I), .DAT_O(DAT_O),
  .ACK_O(ACK_O));
